// file: design/serdes_pkg.sv
// Purpose : Shared constants for the 10-bit serializer and its lock monitor
// Assumes : One core clock; all pins sampled by that clock
// Notes   : Word layout is start clock bit, ten data bits, stop clock bit
package serdes_pkg;

  // ==========================================================
  // Word layout
  localparam int              DATA_W        = 10;
  localparam int              WORD_W        = DATA_W + 2;
  localparam logic            CLK_BIT_START = 1'h1;
  localparam logic            CLK_BIT_STOP  = 1'h0;
  // Five ones then five zeros, so the receiver sees a mid-word edge too
  localparam logic [DATA_W-1:0] TRAIN_PATTERN = 10'h3e0;

  // ==========================================================
  // Link behaviour counts
  localparam int              TRAIN_MIN     = 1024;
  localparam int              LOSS_COUNT    = 4;
  localparam int              SUSPECT_WORDS = 5;
  localparam int              LOCK_GOOD     = 4;

  // ==========================================================
  // Pin sampling
  localparam int              PIN_TRANSMIT_CLOCK      = 0;
  localparam int              PIN_DATA_LO   = 1;
  localparam int              PIN_EDGE      = PIN_DATA_LO + DATA_W;
  localparam int              PIN_OE        = PIN_EDGE + 1;
  localparam int              PIN_PDN       = PIN_OE + 1;
  localparam int              PIN_REQ_A     = PIN_PDN + 1;
  localparam int              PIN_REQ_B     = PIN_REQ_A + 1;
  localparam int              PIN_W         = PIN_REQ_B + 1;
  localparam logic [PIN_W-1:0] PIN_RESET    = 16'h0000;

endpackage

// file: design/lock_monitor.sv
// Purpose : Receive-side lock detector and suspect-word marking
// Assumes : One received 12-bit word per valid pulse
// Notes   : Output words trail the input by the suspect window
`timescale 1ns/1ns
module lock_monitor
#(
  parameter int LOCK_GOOD_WORDS = serdes_pkg::LOCK_GOOD
)
(
  // Clock and reset
  input  wire logic                          core_clk_in,
  input  wire logic                          rst_in,
  // Received words
  input  wire logic [serdes_pkg::WORD_W-1:0] rx_word_in,
  input  wire logic                          rx_word_valid_in,
  // Recovered data and lock
  output logic      [serdes_pkg::DATA_W-1:0] rx_data_out,
  output logic                               rx_data_valid_out,
  output logic                               rx_suspect_out,
  output logic                               lock_n_out
);
  import serdes_pkg::*;

  localparam int GOOD_W = $clog2(LOCK_GOOD_WORDS + 1);
  localparam int BAD_W  = $clog2(LOSS_COUNT + 1);

  logic              clk_ok;
  logic              lose_now;
  logic [BAD_W-1:0]  bad_cnt_r;
  logic [GOOD_W-1:0] good_cnt_r;
  logic              lock_n_r;
  logic [DATA_W-1:0] dl_data_r [SUSPECT_WORDS];
  logic              dl_sus_r  [SUSPECT_WORDS];

  assign clk_ok   = (rx_word_in[WORD_W-1] == CLK_BIT_START) && (rx_word_in[0] == CLK_BIT_STOP);
  assign lose_now = rx_word_valid_in && !clk_ok && !lock_n_r
                    && (bad_cnt_r == BAD_W'(LOSS_COUNT - 1));

  // ==========================================================
  // Lock detector
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      bad_cnt_r  <= '0;
      good_cnt_r <= '0;
      lock_n_r   <= 1'b1;
    end
    else if (rx_word_valid_in)
    begin
      if (clk_ok)
      begin
        bad_cnt_r <= '0;
        if (lock_n_r && (good_cnt_r == GOOD_W'(LOCK_GOOD_WORDS - 1)))
        begin
          lock_n_r   <= 1'b0;
          good_cnt_r <= '0;
        end
        else if (lock_n_r)
          good_cnt_r <= good_cnt_r + GOOD_W'(1);
      end
      else
      begin
        good_cnt_r <= '0;
        // Only a run of bad words drops lock; one glitch is tolerated
        if (lose_now)
        begin
          lock_n_r  <= 1'b1;
          bad_cnt_r <= '0;
        end
        else if (bad_cnt_r != BAD_W'(LOSS_COUNT - 1))
          bad_cnt_r <= bad_cnt_r + BAD_W'(1);
      end
    end
  end

  // ==========================================================
  // Suspect window: words still in the line when lock drops are marked
  genvar i;
  generate
    for (i = 0; i < SUSPECT_WORDS; i++)
    begin : g_line
      always_ff @(posedge core_clk_in)
      begin
        if (rst_in)
        begin
          dl_data_r[i] <= '0;
          dl_sus_r[i]  <= 1'b1;
        end
        else if (rx_word_valid_in)
        begin
          if (i == 0)
          begin
            dl_data_r[i] <= rx_word_in[WORD_W-2:1];
            dl_sus_r[i]  <= lock_n_r || !clk_ok || lose_now;
          end
          else
          begin
            dl_data_r[i] <= dl_data_r[i-1];
            dl_sus_r[i]  <= dl_sus_r[i-1] || lose_now;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      rx_data_out       <= '0;
      rx_data_valid_out <= 1'b0;
      rx_suspect_out    <= 1'b1;
    end
    else
    begin
      rx_data_valid_out <= rx_word_valid_in;
      if (rx_word_valid_in)
      begin
        rx_data_out    <= dl_data_r[SUSPECT_WORDS-1];
        rx_suspect_out <= dl_sus_r[SUSPECT_WORDS-1] || lose_now;
      end
    end
  end

  assign lock_n_out = lock_n_r;

endmodule

// file: design/serdes_tx_sync_lock_recovery.sv
// Purpose : 10-bit serializer with training symbols, plus link lock monitor
// Assumes : All serializer pins are asynchronous to core_clk_in
// Notes   : One serial bit per core cycle; a word needs 12 core cycles
`timescale 1ns/1ns

// Behaviour
// - Ten data inputs are captured into a 10-bit register once per transmit clock.
// - Edge select high samples on rising transmit clock edge, low on falling.
// - Output enable low floats both differential serial outputs.
// - Power down low stops the PLL, floats outputs, enters sleep.
// - A training request sends at least 1024 training symbols, even if released.
// - Training continues while the request stays high past the minimum.
// - The two training request inputs are ORed together.
// - Lock is lost only after four consecutive words with bad clock bits.
// - Up to five words before lock loss are treated as suspect.
// - Active-low lock indicator is high unless locked, low once locked.
// - Every word carries two embedded clock bits besides ten data bits.
module serdes_tx_sync_lock_recovery
#(
  parameter int TRAIN_MIN_WORDS = serdes_pkg::TRAIN_MIN,
  parameter int LOCK_GOOD_WORDS = serdes_pkg::LOCK_GOOD
)
(
  // Clock and reset
  input  wire logic                          core_clk_in,
  input  wire logic                          rst_in,
  // Parallel source side
  input  wire logic                          transmit_clock_in,
  input  wire logic                          tx_edge_select_in,
  input  wire logic [serdes_pkg::DATA_W-1:0] tx_data_in,
  // Control pins
  input  wire logic                          serial_output_enable_in,
  input  wire logic                          power_down_n_in,
  input  wire logic                          training_request_a_in,
  input  wire logic                          training_request_b_in,
  // Serial line
  output logic                               serial_p_out,
  output logic                               serial_p_oe_out,
  output logic                               serial_n_out,
  output logic                               serial_n_oe_out,
  // Word view and status
  output logic      [serdes_pkg::WORD_W-1:0] tx_word_out,
  output logic                               tx_word_strobe_out,
  output logic                               training_active_out,
  output logic                               pll_running_out,
  // Receive side lock monitor
  input  wire logic [serdes_pkg::WORD_W-1:0] rx_word_in,
  input  wire logic                          rx_word_valid_in,
  output logic      [serdes_pkg::DATA_W-1:0] rx_data_out,
  output logic                               rx_data_valid_out,
  output logic                               rx_suspect_out,
  output logic                               lock_n_out
);
  import serdes_pkg::*;

  typedef enum logic [1:0] {ST_SLEEP, ST_DATA, ST_TRAIN} tx_state_e;

  localparam int CNT_W = $clog2(TRAIN_MIN_WORDS + 1);
  localparam int BIT_W = $clog2(WORD_W + 1);

  logic [PIN_W-1:0]  pin_raw;
  logic [PIN_W-1:0]  s1_r;
  logic [PIN_W-1:0]  s2_r;
  logic [PIN_W-1:0]  s3_r;
  logic [PIN_W-1:0]  level_r;
  logic              transmit_clock_rise;
  logic              transmit_clock_fall;
  logic              capture;
  logic              pd_n;
  logic              req;
  logic              req_prev_r;
  logic              req_rise;
  tx_state_e         state_r;
  logic [CNT_W-1:0]  train_cnt_r;
  logic              train_done;
  logic [DATA_W-1:0] data_in_r;
  logic              load_r;
  logic              load_train_r;
  logic [WORD_W-1:0] word_nxt;
  logic [WORD_W-1:0] shift_r;
  logic [WORD_W-1:0] word_r;
  logic              strobe_r;
  logic              drive_r;

  // ==========================================================
  // Pin sampling: three stages, a change counts when stages two and three agree
  assign pin_raw = {training_request_b_in, training_request_a_in, power_down_n_in,
                    serial_output_enable_in, tx_edge_select_in, tx_data_in,
                    transmit_clock_in};

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      s1_r <= PIN_RESET;
      s2_r <= PIN_RESET;
      s3_r <= PIN_RESET;
    end
    else
    begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  genvar i;
  generate
    for (i = 0; i < PIN_W; i++)
    begin : g_pin
      always_ff @(posedge core_clk_in)
      begin
        if (rst_in)
          level_r[i] <= PIN_RESET[i];
        else if (s2_r[i] == s3_r[i])
          level_r[i] <= s3_r[i];
      end
    end
  endgenerate

  assign transmit_clock_rise = (s2_r[PIN_TRANSMIT_CLOCK] == s3_r[PIN_TRANSMIT_CLOCK]) && s3_r[PIN_TRANSMIT_CLOCK] && !level_r[PIN_TRANSMIT_CLOCK];
  assign transmit_clock_fall = (s2_r[PIN_TRANSMIT_CLOCK] == s3_r[PIN_TRANSMIT_CLOCK]) && !s3_r[PIN_TRANSMIT_CLOCK] && level_r[PIN_TRANSMIT_CLOCK];
  assign capture   = pd_n && (level_r[PIN_EDGE] ? transmit_clock_rise : transmit_clock_fall);
  assign pd_n      = level_r[PIN_PDN];
  assign req       = level_r[PIN_REQ_A] | level_r[PIN_REQ_B];
  assign req_rise  = req && !req_prev_r;

  // ==========================================================
  // Training request tracking; cleared in sleep so a held request retrains on wake
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      req_prev_r <= 1'b0;
    else
      req_prev_r <= pd_n && req;
  end

  assign train_done = (train_cnt_r == CNT_W'(TRAIN_MIN_WORDS));

  // ==========================================================
  // Mode control
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      state_r <= ST_SLEEP;
    else if (!pd_n)
      state_r <= ST_SLEEP;
    else
    begin
      unique case (state_r)
        ST_SLEEP:
          state_r <= req ? ST_TRAIN : ST_DATA;
        ST_DATA:
          if (req_rise)
            state_r <= ST_TRAIN;
        ST_TRAIN:
          // A released request still runs the full minimum; a held one keeps going
          if (!req && train_done && !req_rise)
            state_r <= ST_DATA;
      endcase
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      train_cnt_r <= '0;
    else if (!pd_n || req_rise || state_r != ST_TRAIN)
      train_cnt_r <= '0;
    else if (load_r && load_train_r && !train_done)
      train_cnt_r <= train_cnt_r + CNT_W'(1);
  end

  // ==========================================================
  // Input register and word build
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      data_in_r    <= '0;
      load_r       <= 1'b0;
      load_train_r <= 1'b0;
    end
    else
    begin
      load_r <= capture;
      if (capture)
      begin
        data_in_r    <= level_r[PIN_EDGE-1:PIN_DATA_LO];
        load_train_r <= (state_r == ST_TRAIN) || req_rise;
      end
    end
  end

  assign word_nxt = {CLK_BIT_START,
                     load_train_r ? TRAIN_PATTERN : data_in_r,
                     CLK_BIT_STOP};

  // ==========================================================
  // Serial shifter; a new word restarts it, so a fast transmit clock truncates
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      shift_r  <= '0;
      word_r   <= '0;
      strobe_r <= 1'b0;
    end
    else
    begin
      strobe_r <= load_r;
      if (load_r)
      begin
        shift_r <= word_nxt;
        word_r  <= word_nxt;
      end
      else
        shift_r <= {shift_r[WORD_W-2:0], CLK_BIT_STOP};
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      drive_r <= 1'b0;
    else
      drive_r <= pd_n && level_r[PIN_OE];
  end

  assign serial_p_out        = shift_r[WORD_W-1];
  assign serial_n_out        = ~shift_r[WORD_W-1];
  assign serial_p_oe_out     = drive_r;
  assign serial_n_oe_out     = drive_r;
  assign tx_word_out         = word_r;
  assign tx_word_strobe_out  = strobe_r;
  assign training_active_out = (state_r == ST_TRAIN);
  assign pll_running_out     = (state_r != ST_SLEEP);

  // ==========================================================
  // Receive side lock monitor
  lock_monitor #(
    .LOCK_GOOD_WORDS (LOCK_GOOD_WORDS)
  ) u_lock (
    .core_clk_in       (core_clk_in),
    .rst_in            (rst_in),
    .rx_word_in        (rx_word_in),
    .rx_word_valid_in  (rx_word_valid_in),
    .rx_data_out       (rx_data_out),
    .rx_data_valid_out (rx_data_valid_out),
    .rx_suspect_out    (rx_suspect_out),
    .lock_n_out        (lock_n_out)
  );

endmodule

// file: test/serdes_link_props.sv
// Purpose : Port-level assertions for the serializer and lock monitor
// Assumes : One core clock domain, synchronous active-high reset
// Notes   : Pin sync latency is taken as under eight core cycles
`timescale 1ns/1ns
module serdes_link_props
#(
  parameter int TRAIN_MIN_WORDS = serdes_pkg::TRAIN_MIN,
  parameter int LOCK_GOOD_WORDS = serdes_pkg::LOCK_GOOD
)
(
  // Clock and pins
  input  wire logic                          core_clk_in,
  input  wire logic                          rst_in,
  input  wire logic                          serial_output_enable_in,
  input  wire logic                          power_down_n_in,
  // Serial and word view
  input  wire logic                          serial_p_out,
  input  wire logic                          serial_p_oe_out,
  input  wire logic                          serial_n_out,
  input  wire logic                          serial_n_oe_out,
  input  wire logic [serdes_pkg::WORD_W-1:0] tx_word_out,
  input  wire logic                          tx_word_strobe_out,
  input  wire logic                          training_active_out,
  input  wire logic                          pll_running_out,
  // Receive side
  input  wire logic [serdes_pkg::WORD_W-1:0] rx_word_in,
  input  wire logic                          rx_word_valid_in,
  input  wire logic                          rx_data_valid_out,
  input  wire logic                          rx_suspect_out,
  input  wire logic                          lock_n_out
);
  import serdes_pkg::*;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // ==========================================================
  // Helper counters; the two low-time counters saturate at 8 so long idle spans stay cheap
  logic [3:0] oe_lo_r;
  logic [3:0] pd_lo_r;
  int         tw_r;
  int         bad_r;
  int         good_r;
  logic       word_bad;
  assign word_bad = !(rx_word_in[WORD_W-1] && !rx_word_in[0]);
  always_ff @(posedge core_clk_in)
    oe_lo_r <= (rst_in || serial_output_enable_in) ? 4'h0 : oe_lo_r + {3'h0, oe_lo_r != 4'h8};
  always_ff @(posedge core_clk_in)
    pd_lo_r <= (rst_in || power_down_n_in) ? 4'h0 : pd_lo_r + {3'h0, pd_lo_r != 4'h8};
  always_ff @(posedge core_clk_in)
    tw_r <= (rst_in || !training_active_out) ? 0 : tw_r + int'(tx_word_strobe_out);
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      bad_r  <= 0;
      good_r <= 0;
    end
    else if (rx_word_valid_in)
    begin
      bad_r  <= word_bad ? bad_r + 1 : 0;
      good_r <= word_bad ? 0 : good_r + 1;
    end
  end
  // ==========================================================
  // Assertions
  chk_oe_low_floats: assert property (oe_lo_r == 4'h8 |-> !serial_p_oe_out && !serial_n_oe_out)
    else $error("serial pins driven while output enable low");
  chk_sleep_state: assert property (pd_lo_r == 4'h8 |-> !pll_running_out && !serial_p_oe_out)
    else $error("pll or driver active in power down");
  chk_diff_pair: assert property (serial_p_oe_out |-> serial_n_oe_out && serial_n_out == !serial_p_out)
    else $error("differential outputs disagree");
  chk_word_frame: assert property (tx_word_strobe_out |-> tx_word_out[WORD_W-1] && !tx_word_out[0] && serial_p_out)
    else $error("word clock bits wrong");
  chk_bit_order: assert property (tx_word_strobe_out |=> serial_p_out == tx_word_out[10] ##1 serial_p_out == tx_word_out[9])
    else $error("serial bit order wrong");
  chk_train_pattern: assert property (tx_word_strobe_out && training_active_out && $past(training_active_out) && $past(training_active_out, 2) |-> tx_word_out[DATA_W:1] == TRAIN_PATTERN)
    else $error("training word not the pattern");
  chk_train_minimum: assert property ($fell(training_active_out) && pll_running_out |-> tw_r >= TRAIN_MIN_WORDS)
    else $error("training ended before minimum count");
  chk_loss_count: assert property ($rose(lock_n_out) |-> bad_r >= LOSS_COUNT && rx_suspect_out)
    else $error("lock lost without four bad words");
  chk_lock_gain: assert property ($fell(lock_n_out) |-> good_r >= LOCK_GOOD_WORDS)
    else $error("lock declared too early");
  chk_rx_valid_follow: assert property (rx_data_valid_out == $past(rx_word_valid_in))
    else $error("received data valid not one cycle after word");
  cov_train: cover property ($rose(training_active_out));
  cov_loss: cover property ($rose(lock_n_out));
  cov_lock: cover property ($fell(lock_n_out));
endmodule

// file: test/serial_rx_model.sv
// Purpose : Far-end deserializer model that reassembles serial words
// Assumes : One serial bit per core cycle, start bit high, idle low
// Notes   : corrupt_in breaks embedded clock bits of whole words
`timescale 1ns/1ns
module serial_rx_model
(
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic        line_p_in,
  input  wire logic        line_oe_in,
  input  wire logic        corrupt_in,
  output logic      [11:0] word_out,
  output logic             valid_out
);
  logic [11:0] sh_r;
  int          cnt_r;
  // Floated line is ignored, so framing restarts at the next start bit
  always_ff @(posedge core_clk_in)
  begin
    valid_out <= 1'b0;
    if (rst_in || !line_oe_in)
      cnt_r <= 0;
    else if (cnt_r == 0)
    begin
      sh_r  <= 12'h001;
      cnt_r <= int'(line_p_in);
    end
    else if (cnt_r == 11)
    begin
      word_out  <= {sh_r[10:0], line_p_in} ^ (corrupt_in ? 12'h801 : 12'h000);
      valid_out <= 1'b1;
      cnt_r     <= 0;
    end
    else
    begin
      sh_r  <= {sh_r[10:0], line_p_in};
      cnt_r <= cnt_r + 1;
    end
  end
endmodule

// file: test/serdes_tx_sync_lock_recovery_tb.sv
// Purpose : Directed bench for serializer, training and lock recovery
// Assumes : Transmit clock period kept at 24 core cycles
// Notes   : Minimum training count shortened to keep the run brief
`timescale 1ns/1ns
module serdes_tx_sync_lock_recovery_tb;
  import serdes_pkg::*;
  localparam int TMIN = 8;
  logic              core_clk_in = 0, rst_in = 1, transmit_clock = 0, sel = 1, oe = 0;
  logic              pdn = 0, req_a = 0, req_b = 0, bad = 0;
  logic [DATA_W-1:0] din = 10'h000;
  logic [DATA_W-1:0] rxd;
  logic [WORD_W-1:0] word, rxw;
  logic              sp, spoe, sn, snoe, strobe, train, pll, rxv, susp, lock_n;
  int                fail_count = 0, cmp_count = 0, cyc = 0, tw = 0;
  logic [DATA_W-1:0] va [3] = '{10'h3ff, 10'h155, 10'h201};
  logic [DATA_W-1:0] vb [3] = '{10'h000, 10'h2aa, 10'h1fe};
  initial forever #4 core_clk_in = ~core_clk_in;
  serdes_tx_sync_lock_recovery #(.TRAIN_MIN_WORDS(TMIN), .LOCK_GOOD_WORDS(LOCK_GOOD)) u_dut (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .transmit_clock_in(transmit_clock),
    .tx_edge_select_in(sel), .tx_data_in(din), .serial_output_enable_in(oe),
    .power_down_n_in(pdn), .training_request_a_in(req_a), .training_request_b_in(req_b),
    .serial_p_out(sp), .serial_p_oe_out(spoe), .serial_n_out(sn), .serial_n_oe_out(snoe),
    .tx_word_out(word), .tx_word_strobe_out(strobe), .training_active_out(train),
    .pll_running_out(pll), .rx_word_in(rxw), .rx_word_valid_in(rxv), .rx_data_out(rxd),
    .rx_data_valid_out(), .rx_suspect_out(susp), .lock_n_out(lock_n));
  serial_rx_model u_far (.core_clk_in(core_clk_in), .rst_in(rst_in), .line_p_in(sp),
    .line_oe_in(spoe), .corrupt_in(bad), .word_out(rxw), .valid_out(rxv));
  // ==========================================================
  // Tasks
  task automatic check(string what, logic [WORD_W-1:0] seen, logic [WORD_W-1:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_n(int n);
    repeat (n) @(negedge core_clk_in);
  endtask
  // Data a is held around the rising edge, b around the falling edge
  task automatic tcycle(logic [DATA_W-1:0] a, logic [DATA_W-1:0] b);
    din = a;
    wait_n(4);
    transmit_clock = 1'b1;
    wait_n(6);
    din = b;
    wait_n(4);
    transmit_clock = 1'b0;
    wait_n(10);
  endtask
  task automatic run(int n);
    repeat (n) tcycle(10'h155, 10'h2aa);
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge core_clk_in)
  begin
    cyc++;
    if (strobe === 1'b1 && train === 1'b1)
      tw++;
    if (cyc == 5000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end
  // ==========================================================
  // Sequence
  initial
  begin
    wait_n(2);
    rst_in = 1'b0;
    check("lock_n reset", lock_n, 1);
    check("oe reset", spoe, 0);
    pdn = 1'b1;
    oe  = 1'b1;
    wait_n(12);
    check("pll awake", pll, 1);
    check("oe driven", spoe, 1);
    // Short request still yields the full minimum
    req_a = 1'b1;
    tcycle(10'h155, 10'h2aa);
    req_a = 1'b0;
    run(12);
    check("train done", train, 0);
    check("train count", tw >= TMIN, 1);
    check("locked", lock_n, 0);
    // Held request keeps training going
    req_b = 1'b1;
    run(14);
    check("train held", train, 1);
    req_b = 1'b0;
    run(3);
    check("train released", train, 0);
    // Capture edge selection
    for (int i = 0; i < 3; i++)
    begin
      sel = 1'b1;
      wait_n(4);
      tcycle(va[i], vb[i]);
      check("rise word", word, {1'b1, va[i], 1'b0});
      sel = 1'b0;
      wait_n(4);
      tcycle(va[i], vb[i]);
      check("fall word", word, {1'b1, vb[i], 1'b0});
    end
    sel = 1'b1;
    wait_n(4);
    run(6);
    wait_n(8);
    check("rx data", rxd, 10'h155);
    check("rx clean", susp, 0);
    // Output enable low floats both pins
    oe = 1'b0;
    wait_n(8);
    check("oe p low", spoe, 0);
    check("oe n low", snoe, 0);
    oe = 1'b1;
    run(2);
    // Lock loss needs four bad words in a row
    bad = 1'b1;
    run(3);
    wait_n(8);
    check("lock held", lock_n, 0);
    run(1);
    wait_n(8);
    check("lock lost", lock_n, 1);
    check("suspect", susp, 1);
    bad   = 1'b0;
    req_a = 1'b1;
    tcycle(10'h155, 10'h2aa);
    req_a = 1'b0;
    run(12);
    check("relock", lock_n, 0);
    // Source resends the last words after relock; they must arrive clean
    run(6);
    wait_n(8);
    check("resent data", rxd, 10'h155);
    check("resent clean", susp, 0);
    // Power down then wake with request high
    pdn = 1'b0;
    wait_n(8);
    check("sleep pll", pll, 0);
    check("sleep oe", spoe, 0);
    req_a = 1'b1;
    pdn   = 1'b1;
    wait_n(12);
    check("wake train", train, 1);
    req_a = 1'b0;
    run(12);
    check("wake done", train, 0);
    tally_and_finish();
  end
endmodule
bind serdes_tx_sync_lock_recovery serdes_link_props #(
  .TRAIN_MIN_WORDS(TRAIN_MIN_WORDS), .LOCK_GOOD_WORDS(LOCK_GOOD_WORDS)) u_props (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .serial_output_enable_in(serial_output_enable_in),
  .power_down_n_in(power_down_n_in), .serial_p_out(serial_p_out),
  .serial_p_oe_out(serial_p_oe_out), .serial_n_out(serial_n_out),
  .serial_n_oe_out(serial_n_oe_out), .tx_word_out(tx_word_out),
  .tx_word_strobe_out(tx_word_strobe_out), .training_active_out(training_active_out),
  .pll_running_out(pll_running_out), .rx_word_in(rx_word_in),
  .rx_word_valid_in(rx_word_valid_in), .rx_data_valid_out(rx_data_valid_out),
  .rx_suspect_out(rx_suspect_out), .lock_n_out(lock_n_out));
